// ===== shared/ets_pkg.sv
package ets_pkg;
  localparam int DATA_W = 256;
  localparam int LANE_W = 8;
  localparam int KEEP_W = DATA_W / LANE_W;
  localparam int FIFO_DEPTH = 8;
  // stored word layout: data, keep, last, bad
  localparam int POS_DATA = 0;
  localparam int POS_KEEP = POS_DATA + DATA_W;
  localparam int POS_LAST = POS_KEEP + KEEP_W;
  localparam int POS_BAD = POS_LAST + 1;
  localparam int WORD_W = POS_BAD + 1;
  // error control character sent in every lane of a bad packet's last word
  localparam logic [7:0] ERR_CTL_CODE = 8'hFE;
  localparam logic RST_SYNC_INIT = 1'b1;
  typedef enum logic [1:0] {
    ETS_IDLE,
    ETS_PACKET,
    ETS_ABORT
  } ets_in_state_t;
endpackage

// ===== shared/ets_stream_if.sv
`timescale 1ns/1ps
interface ets_stream_if #(parameter int W = 8);
  logic inValid;
  logic inReady;
  logic [W-1:0] inData;
  logic outValid;
  logic outReady;
  logic [W-1:0] outData;
  modport fifo(input inValid, inData, outReady, output inReady, outValid, outData);
  modport user(output inValid, inData, outReady, input inReady, outValid, outData);
endinterface

// ===== hdl/ets_fifo.sv
`timescale 1ns/1ps
module ets_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clr,
  ets_stream_if.fifo bus
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("ets_fifo depth must be a power of two");
  end
  if ($bits(bus.inData) != WIDTH) begin : g_bad_width
    $error("ets_fifo width differs from interface width");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] cnt;
  logic push;
  logic pop;

  assign bus.inReady = (cnt != DEPTH[AW:0]);
  assign bus.outValid = (cnt != '0);
  assign bus.outData = mem[rdPtr];
  assign push = bus.inValid && bus.inReady;
  assign pop = bus.outValid && bus.outReady;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr] <= bus.inData;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      cnt <= '0;
    end else if (clr) begin
      wrPtr <= '0;
      rdPtr <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      unique case ({push, pop})
        2'b10: cnt <= cnt + 1'b1;
        2'b01: cnt <= cnt - 1'b1;
        default: cnt <= cnt;
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst || clr);

  a_fifo_no_overrun: assert property (cnt == DEPTH[AW:0] |-> !push) // [R9]
    else $error("fifo written while full");
  a_fifo_count_step: assert property (push && !pop |=> cnt == $past(cnt) + 1'b1) // [R9]
    else $error("fifo count did not step on push");
endmodule

// ===== hdl/ets_tx_port.sv
`timescale 1ns/1ps
// Functional notes
// [R1] all stream signals on core_clk rising edge
// [R2] user holds rxReset high until clock stable
// [R3] rxReset resynchronized before use
// [R4] user holds txReset high until clock stable
// [R5] txReset resynchronized before use
// [R6] one 256-bit data bus, 32 keep bits
// [R7] 32 byte lanes, keep bit n qualifies lane
// [R8] user raises tvalid with data and keep
// [R9] beat accepted when tvalid and tready high
// [R10] user holds beat while tready low
// [R11] tlast marks final beat, one transfer
// [R12] final keep count equals valid bytes
// [R13] tuser on last beat marks packet bad
// [R14] after tlast inputs ignored until tvalid
// [R15] bad packet: error code, no FCS
// [R16] tvalid may stay high; tready throttles
// [R17] tvalid drop before tlast is underrun
// [R18] keep full mid-packet, contiguous at end
module ets_tx_port
  import ets_pkg::*;
#(
  parameter int DATA_WIDTH = ets_pkg::DATA_W,
  parameter int DEPTH = ets_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic txReset,
  input wire logic rxReset,
  output logic rxResetSync,
  input wire logic s_axis_tvalid,
  output logic s_axis_tready,
  input wire logic [ets_pkg::DATA_W-1:0] s_axis_tdata,
  input wire logic [ets_pkg::KEEP_W-1:0] s_axis_tkeep,
  input wire logic s_axis_tlast,
  input wire logic s_axis_tuser,
  output logic lineValid,
  input wire logic lineReady,
  output logic [ets_pkg::DATA_W-1:0] lineData,
  output logic [ets_pkg::KEEP_W-1:0] lineKeep,
  output logic [ets_pkg::KEEP_W-1:0] lineCtl,
  output logic lineLast,
  output logic lineFcsEn,
  output logic underrun
);
  import ets_pkg::*;

  // [R6] fixed bus widths
  if (DATA_WIDTH != DATA_W || DATA_W != KEEP_W * LANE_W) begin : g_bad_width
    $error("ets_tx_port serves only the 256-bit bus with byte keep");
  end
  if (DEPTH < 2) begin : g_bad_depth
    $error("ets_tx_port needs a fifo depth of at least two");
  end

  logic txRstMeta;
  logic txRst;
  logic rxRstMeta;
  ets_in_state_t st;
  logic accept;
  logic abortNow;
  logic [WORD_W-1:0] popWord;
  logic popBad;
  logic popLast;
  logic [KEEP_W-1:0] popKeep;
  logic [DATA_W-1:0] popData;
  logic [DATA_W-1:0] next_lineData;
  logic loadOut;

  ets_stream_if #(.W(WORD_W)) fq ();

  ets_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .clr(txRst),
    .bus(fq)
  );

  // [R5] two-stage resync of transmit reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      txRstMeta <= RST_SYNC_INIT;
      txRst <= RST_SYNC_INIT;
    end else begin
      txRstMeta <= txReset;
      txRst <= txRstMeta;
    end
  end

  // [R3] two-stage resync of receive reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rxRstMeta <= RST_SYNC_INIT;
      rxResetSync <= RST_SYNC_INIT;
    end else begin
      rxRstMeta <= rxReset;
      rxResetSync <= rxRstMeta;
    end
  end

  // [R16] tready follows fifo space, held low while an abort marker is pending or txRst is high
  assign s_axis_tready = fq.inReady && (st != ETS_ABORT) && !txRst;
  // [R9] beat accepted on tvalid and tready
  assign accept = s_axis_tvalid && s_axis_tready;
  // [R17] tvalid dropped inside a packet
  assign abortNow = (st == ETS_PACKET) && !s_axis_tvalid && !txRst;

  // [R14] nothing is pushed unless tvalid, or a pending abort marker
  assign fq.inValid = !txRst && ((st == ETS_ABORT) || (s_axis_tvalid && st != ETS_ABORT));

  // abort marker is a bad last word with no lanes, so the line side closes the frame
  always_comb begin
    fq.inData = '0;
    if (st == ETS_ABORT) begin
      fq.inData[POS_LAST] = 1'b1;
      fq.inData[POS_BAD] = 1'b1;
    end else begin
      fq.inData[POS_DATA +: DATA_W] = s_axis_tdata;
      fq.inData[POS_KEEP +: KEEP_W] = s_axis_tkeep;
      fq.inData[POS_LAST] = s_axis_tlast;
      // [R13] tuser counts only on the last beat
      fq.inData[POS_BAD] = s_axis_tuser && s_axis_tlast;
    end
  end

  // [R1] packet tracking on core_clk
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= ETS_IDLE;
    end else if (txRst) begin
      st <= ETS_IDLE;
    end else begin
      unique case (st)
        ETS_IDLE: begin
          if (accept && !s_axis_tlast) begin
            st <= ETS_PACKET;
          end
        end
        ETS_PACKET: begin
          // [R17] underrun closes the packet
          if (!s_axis_tvalid) begin
            st <= ETS_ABORT;
          end else if (accept && s_axis_tlast) begin
            st <= ETS_IDLE;
          end
        end
        ETS_ABORT: begin
          if (fq.inReady) begin
            st <= ETS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      underrun <= 1'b0;
    end else begin
      underrun <= abortNow;
    end
  end

  assign popWord = fq.outData;
  assign popBad = popWord[POS_BAD];
  assign popLast = popWord[POS_LAST];
  assign popKeep = popWord[POS_KEEP +: KEEP_W];
  assign popData = popWord[POS_DATA +: DATA_W];

  // output register doubles as the line stage; stall reaches the fifo
  assign fq.outReady = !lineValid || lineReady;
  assign loadOut = fq.outValid && fq.outReady;

  // [R7] lane n gated by keep bit n; [R15] error code in every lane
  for (genvar n = 0; n < KEEP_W; n++) begin : g_lane
    assign next_lineData[n*LANE_W +: LANE_W] = popBad ? ERR_CTL_CODE :
      (popKeep[n] ? popData[n*LANE_W +: LANE_W] : '0);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lineValid <= 1'b0;
    end else if (txRst) begin
      lineValid <= 1'b0;
    end else if (fq.outReady) begin
      lineValid <= fq.outValid;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lineData <= '0;
      lineKeep <= '0;
      lineCtl <= '0;
      lineLast <= 1'b0;
      lineFcsEn <= 1'b0;
    end else if (loadOut) begin
      lineData <= next_lineData;
      lineKeep <= popBad ? '1 : popKeep;
      // [R15] bad word marked as control
      lineCtl <= popBad ? '1 : '0;
      lineLast <= popLast;
      // [R15] no FCS for the bad packet only
      lineFcsEn <= popLast && !popBad;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst || txRst);

  sequence s_drop_in_packet;
    (st == ETS_PACKET) && !s_axis_tvalid;
  endsequence

  sequence s_abort_marker;
    (st == ETS_ABORT) && !s_axis_tready ##[0:300] fq.inValid && fq.inReady;
  endsequence

  a_underrun_flag: assert property (s_drop_in_packet |=> underrun ##0 s_abort_marker) // [R17]
    else $error("underrun not flagged or marker not pushed");
  a_accept_push: assert property (accept |-> fq.inValid && fq.inReady) // [R9]
    else $error("accepted beat not pushed");
  a_idle_ignore: assert property ((st == ETS_IDLE) && !s_axis_tvalid |-> !fq.inValid) // [R14]
    else $error("input taken outside a packet");
  a_bad_word_code: assert property (lineValid && lineCtl[0] |-> lineLast // [R15]
      && lineData[LANE_W-1:0] == ERR_CTL_CODE && !lineFcsEn)
    else $error("bad word without error code or with fcs");
  a_bad_from_tuser: assert property (accept && s_axis_tlast && s_axis_tuser // [R13]
      |-> fq.inData[POS_BAD])
    else $error("tuser on last beat not kept as bad");
  a_good_fcs_on: assert property (lineValid && lineLast && !lineCtl[0] |-> lineFcsEn) // [R13]
    else $error("good packet without fcs");
  // lane 1 stands for all lanes; keep, control and data must name the same lane
  a_lane_masked: assert property (lineValid && !lineCtl[1] && !lineKeep[1] // [R7]
      |-> lineData[2*LANE_W-1:LANE_W] == '0)
    else $error("unkept lane carries data");
  a_line_hold: assert property (lineValid && !lineReady |=> lineValid // [R16]
      && $stable(lineData) && $stable(lineLast))
    else $error("line word changed while stalled");
  a_tx_rst_sync: assert property (disable iff (!nrst) txReset [*3] |-> txRst // [R5]
      && !s_axis_tready)
    else $error("transmit reset not applied after two edges");
  // copy lags two edges, so a short reset pulse still shows one edge after the fall
  a_rx_rst_sync: assert property (disable iff (!nrst) $fell(rxReset) |-> // [R3]
      ##1 rxResetSync ##1 !rxResetSync)
    else $error("receive reset release not two edges late");
endmodule

// ===== dv/ets_src_model.sv
`timescale 1ns/1ps
module ets_src_model
  import ets_pkg::*;
(
  input wire logic core_clk,
  input wire logic tready,
  output logic tvalid,
  output logic [ets_pkg::DATA_W-1:0] tdata,
  output logic [ets_pkg::KEEP_W-1:0] tkeep,
  output logic tlast,
  output logic tuser
);
  initial begin
    tvalid = 1'b0;
    tdata = '0;
    tkeep = '0;
    tlast = 1'b0;
    tuser = 1'b0;
  end
  function automatic logic [DATA_W-1:0] pat(input logic [7:0] s, input int b);
    for (int n = 0; n < KEEP_W; n++) pat[8*n +: 8] = s + 8'(b * KEEP_W + n);
  endfunction
  function automatic logic [KEEP_W-1:0] keepOf(input int n);
    keepOf = (n >= KEEP_W) ? '1 : KEEP_W'((64'h1 << n) - 1);
  endfunction
  task automatic send(input logic [DATA_W-1:0] d, input logic [KEEP_W-1:0] k,
                      input logic l, input logic u);
    tvalid <= 1'b1;
    tdata <= d;
    tkeep <= k;
    tlast <= l;
    tuser <= u;
    @(posedge core_clk);
    while (tready !== 1'b1) @(posedge core_clk);
  endtask
  // released bus shows a changed pattern, not the old beat
  task automatic idle(input int n);
    tvalid <= 1'b0;
    tdata <= ~tdata;
    tkeep <= ~tkeep;
    tlast <= ~tlast;
    tuser <= ~tuser;
    repeat (n) @(posedge core_clk);
  endtask
  task automatic packet(input int beats, input int lastB, input logic bad, input logic [7:0] s);
    for (int b = 0; b < beats; b++)
      send(pat(s, b), (b == beats - 1) ? keepOf(lastB) : '1, b == beats - 1, bad && b == beats - 1);
  endtask
endmodule

// ===== dv/eth_tx_stream_256b_client_port_tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("BAD %0t %s", $time, msg); \
    end \
  end
module eth_tx_stream_256b_client_port_tb_top;
  import ets_pkg::*;
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [KEEP_W-1:0] keep;
    logic [KEEP_W-1:0] ctl;
    logic last;
    logic fcs;
  } ets_word_t;
  typedef struct packed {int beats; int lastB; logic bad;} ets_row_t;
  ets_row_t rows[6] = '{'{1, 32, 1'b0}, '{1, 1, 1'b0}, '{2, 17, 1'b0}, '{3, 31, 1'b1},
                        '{1, 1, 1'b1}, '{4, 8, 1'b0}};
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic txReset = 1'b1;
  logic rxReset = 1'b1;
  logic lineReady = 1'b0;
  logic holdLine = 1'b0;
  logic slowLine = 1'b0;
  logic rxResetSync, s_axis_tvalid, s_axis_tready, s_axis_tlast, s_axis_tuser;
  logic [DATA_W-1:0] s_axis_tdata, lineData;
  logic [KEEP_W-1:0] s_axis_tkeep, lineKeep, lineCtl;
  logic lineValid, lineLast, lineFcsEn, underrun;
  int failures = 0;
  int checks_done = 0;
  int underruns = 0;
  ets_word_t expQ[$];
  ets_word_t expW;
  always #10 core_clk = ~core_clk;
  ets_src_model src (.core_clk(core_clk), .tready(s_axis_tready), .tvalid(s_axis_tvalid),
    .tdata(s_axis_tdata), .tkeep(s_axis_tkeep), .tlast(s_axis_tlast), .tuser(s_axis_tuser));
  ets_tx_port DUT (.core_clk(core_clk), .nrst(nrst), .txReset(txReset), .rxReset(rxReset),
    .rxResetSync(rxResetSync), .s_axis_tvalid(s_axis_tvalid), .s_axis_tready(s_axis_tready),
    .s_axis_tdata(s_axis_tdata), .s_axis_tkeep(s_axis_tkeep), .s_axis_tlast(s_axis_tlast),
    .s_axis_tuser(s_axis_tuser), .lineValid(lineValid), .lineReady(lineReady),
    .lineData(lineData), .lineKeep(lineKeep), .lineCtl(lineCtl), .lineLast(lineLast),
    .lineFcsEn(lineFcsEn), .underrun(underrun));
  always @(posedge core_clk) lineReady <= holdLine ? 1'b0 : (slowLine ? ~lineReady : 1'b1);
  always @(posedge core_clk) if (underrun === 1'b1) underruns++;
  always @(posedge core_clk) begin
    if (nrst && lineValid === 1'b1 && lineReady === 1'b1) begin
      if (expQ.size() == 0) begin
        `CHK(1'b1, 1'b0, "unexpected line word");
      end else begin
        expW = expQ.pop_front();
        `CHK(lineData, expW.data, "line data");
        `CHK(lineKeep, expW.keep, "line keep");
        `CHK(lineCtl, expW.ctl, "line control");
        `CHK(lineLast, expW.last, "line last");
        `CHK(lineFcsEn, expW.fcs, "frame check enable");
      end
    end
  end
  task automatic expect_packet(input ets_row_t r, input logic [7:0] s);
    ets_word_t w;
    logic [DATA_W-1:0] d;
    for (int b = 0; b < r.beats; b++) begin
      d = src.pat(s, b);
      w.last = (b == r.beats - 1);
      w.keep = w.last ? src.keepOf(r.lastB) : '1;
      for (int n = 0; n < KEEP_W; n++) w.data[8*n +: 8] = w.keep[n] ? d[8*n +: 8] : 8'h00;
      w.ctl = '0;
      w.fcs = w.last && !r.bad;
      if (w.last && r.bad) begin
        w.data = {KEEP_W{ERR_CTL_CODE}};
        w.keep = '1;
        w.ctl = '1;
      end
      expQ.push_back(w);
    end
  endtask
  task automatic drain(input string name);
    for (int t = 0; t < 300 && expQ.size() > 0; t++) @(posedge core_clk);
    `CHK(expQ.size(), 0, "words missing");
    $display("test %s done", name);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    `CHK(s_axis_tready, 1'b0, "ready in reset");
    `CHK(rxResetSync, 1'b1, "rx reset copy in reset");
    @(posedge core_clk);
    nrst <= 1'b1;
    // both resets stay high while the clock settles
    repeat (3) @(posedge core_clk);
    txReset <= 1'b0;
    rxReset <= 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK(rxResetSync, 1'b1, "rx reset released early");
    `CHK(s_axis_tready, 1'b0, "ready rose early");
    @(negedge core_clk);
    `CHK(rxResetSync, 1'b0, "rx reset copy stuck");
    `CHK(s_axis_tready, 1'b1, "ready after reset");
    $display("test reset done");
    @(posedge core_clk);
    foreach (rows[i]) begin
      slowLine <= rows[i].bad;
      expect_packet(rows[i], 8'(i * 16));
      src.packet(rows[i].beats, rows[i].lastB, rows[i].bad, 8'(i * 16));
    end
    src.idle(2);
    drain("packets");
    `CHK(underruns, 0, "false underrun");
    holdLine <= 1'b1;
    expect_packet(ets_row_t'{12, 5, 1'b0}, 8'hA0);
    fork
      src.packet(12, 5, 1'b0, 8'hA0);
    join_none
    repeat (30) @(posedge core_clk);
    `CHK(s_axis_tready, 1'b0, "ready with full buffer");
    holdLine <= 1'b0;
    wait fork;
    src.idle(1);
    drain("backpressure");
    // tuser away from the last beat must not spoil the packet
    expect_packet(ets_row_t'{2, 4, 1'b0}, 8'h33);
    src.send(src.pat(8'h33, 0), '1, 1'b0, 1'b1);
    src.send(src.pat(8'h33, 1), src.keepOf(4), 1'b1, 1'b0);
    src.idle(1);
    drain("tuser mid packet");
    expect_packet(ets_row_t'{2, 32, 1'b1}, 8'h55);
    src.send(src.pat(8'h55, 0), '1, 1'b0, 1'b0);
    src.idle(6);
    drain("underrun");
    `CHK(underruns, 1, "underrun pulse count");
    txReset <= 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK(s_axis_tready, 1'b0, "ready under tx reset");
    $display("test tx reset done");
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    end_of_test();
  end
endmodule
